// File: rvao_map.svh
`ifndef RVAO_MAP_SVH
`define RVAO_MAP_SVH
// Register byte offsets
`define RVAO_OFS_DISP_CTRL 8'h00
`define RVAO_OFS_OP_MODE 8'h04
`define RVAO_OFS_ZOOM 8'h08
`define RVAO_OFS_BLINK 8'h0c
`define RVAO_OFS_BASE_DOT 8'h10
`define RVAO_OFS_WIN_DOT 8'h14
`define RVAO_OFS_STATUS 8'h18
// Display control field positions
`define RVAO_DC_ATTR_LSB 0
`define RVAO_DC_BASE_EN 8
`define RVAO_DC_UPPER_EN 9
`define RVAO_DC_LOWER_EN 10
// Operation mode field position
`define RVAO_OM_SWS 0
// Attribute word positions
`define RVAO_AW_DOT_LSB 8
`define RVAO_AW_ZOOM_LSB 12
// Reset values
`define RVAO_RST_DISP_CTRL 16'h0000
`define RVAO_RST_BLINK 16'h0101
// Fields per blink unit
`define RVAO_FIELDS_PER_UNIT 3'h4
`endif

// File: rvao_pkg.sv
package rvao_pkg;
  // Background screen codes on the split lines
  typedef enum logic [1:0] {
    RVAO_SCR_NONE = 2'b00,
    RVAO_SCR_BASE = 2'b01,
    RVAO_SCR_UPPER = 2'b10,
    RVAO_SCR_LOWER = 2'b11
  } rvao_screen_t;
endpackage

// File: rvao_attr_out.sv
`timescale 1ns/1ps
`include "rvao_map.svh"
// What this block does
// - Drive 20-bit attribute word before hsync rises
// - Low eight bits carry user attribute code
// - New attribute shows after current raster
// - Bits 8-11 carry background start dot
// - Window scroll bit selects window dot
// - Scroll dot held, valid inside area
// - Bits 12-15 carry encoded zoom factor
// - Zoom applies to base screen only
// - Split code 00 none, 01 base
// - Split code output only when the selected screen is enabled
// - Blink lines toggle per four-field units
module rvao_attr_out (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  input wire logic hsync_lead_in,
  input wire logic vsync_pulse_in,
  input wire logic area_start_in,
  input wire logic area_active_in,
  input wire rvao_pkg::rvao_screen_t screen_sel_in,
  output logic [15:0] frame_addr_data_bus_out,
  output logic frame_addr_data_oe_out,
  output logic [3:0] high_addr_raster_lines_out
);
  import rvao_pkg::*;

  logic [15:0] display_control_register; // Attribute field and screen enables
  logic [15:0] operation_mode_register; // Window smooth scroll bit
  logic [3:0] zoom_factor_register; // Zoom factor minus one
  logic [15:0] blink_control_register; // Two blink periods in units
  logic [3:0] base_dot; // Background start dot
  logic [3:0] win_dot; // Window start dot
  logic [3:0] held_dot; // Dot captured at area start
  logic [2:0] field_cnt; // Fields within one blink unit
  logic [7:0] blink_cnt [2]; // Units elapsed per blink line
  logic [1:0] blink_state; // Current blink levels
  logic [1:0] split_code; // Last split code driven
  logic [1:0] next_split; // Split code for this raster
  logic [3:0] next_zoom; // Zoom code for this raster
  logic [3:0] next_dot; // Dot code for this raster
  logic unit_tick; // End of a four-field unit

  // Register writes
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      display_control_register <= `RVAO_RST_DISP_CTRL;
      operation_mode_register <= 16'h0000;
      zoom_factor_register <= 4'h0;
      blink_control_register <= `RVAO_RST_BLINK;
      base_dot <= 4'h0;
      win_dot <= 4'h0;
    end else if (reg_wr_in) begin
      unique case (reg_addr_in)
        `RVAO_OFS_DISP_CTRL: display_control_register <= reg_wdata_in;
        `RVAO_OFS_OP_MODE: operation_mode_register <= reg_wdata_in;
        `RVAO_OFS_ZOOM: zoom_factor_register <= reg_wdata_in[3:0];
        `RVAO_OFS_BLINK: blink_control_register <= reg_wdata_in;
        `RVAO_OFS_BASE_DOT: base_dot <= reg_wdata_in[3:0];
        `RVAO_OFS_WIN_DOT: win_dot <= reg_wdata_in[3:0];
        default: begin
          // Unmapped or read-only, ignored
        end
      endcase
    end
  end

  // Register reads, data in the following cycle only
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        `RVAO_OFS_DISP_CTRL: reg_rdata_out <= display_control_register;
        `RVAO_OFS_OP_MODE: reg_rdata_out <= operation_mode_register;
        `RVAO_OFS_ZOOM: reg_rdata_out <= {12'h000, zoom_factor_register};
        `RVAO_OFS_BLINK: reg_rdata_out <= blink_control_register;
        `RVAO_OFS_BASE_DOT: reg_rdata_out <= {12'h000, base_dot};
        `RVAO_OFS_WIN_DOT: reg_rdata_out <= {12'h000, win_dot};
        `RVAO_OFS_STATUS: reg_rdata_out <= {8'h00, blink_state, split_code, held_dot};
        default: reg_rdata_out <= 16'h0000;
      endcase
    end else begin
      reg_rdata_out <= 16'h0000;
    end
  end

  // Scroll dot captured once at area start and held
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      held_dot <= 4'h0;
    end else if (area_start_in) begin
      // Window dot when window smooth scroll is set
      held_dot <= operation_mode_register[`RVAO_OM_SWS] ? win_dot : base_dot;
    end
  end

  // Split code, zoom and dot for the coming raster
  always_comb begin
    next_split = RVAO_SCR_NONE;
    unique case (screen_sel_in)
      RVAO_SCR_BASE: begin
        if (display_control_register[`RVAO_DC_BASE_EN]) next_split = RVAO_SCR_BASE;
      end
      RVAO_SCR_UPPER: begin
        if (display_control_register[`RVAO_DC_UPPER_EN]) next_split = RVAO_SCR_UPPER;
      end
      RVAO_SCR_LOWER: begin
        if (display_control_register[`RVAO_DC_LOWER_EN]) next_split = RVAO_SCR_LOWER;
      end
      RVAO_SCR_NONE: next_split = RVAO_SCR_NONE;
    endcase
    // Zoom only on the base screen, factor one elsewhere
    next_zoom = (next_split == RVAO_SCR_BASE) ? zoom_factor_register : 4'h0;
    // Dot only valid inside the area
    next_dot = area_active_in ? held_dot : 4'h0;
  end

  // Field counter, one tick every four fields
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      field_cnt <= 3'h0;
    end else if (vsync_pulse_in) begin
      field_cnt <= (field_cnt == `RVAO_FIELDS_PER_UNIT - 3'h1) ? 3'h0 : field_cnt + 3'h1;
    end
  end
  assign unit_tick = vsync_pulse_in && (field_cnt == `RVAO_FIELDS_PER_UNIT - 3'h1);

  // Blink lines, each toggles after its period of units
  genvar g;
  for (g = 0; g < 2; g++) begin : g_blink
    always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
        blink_cnt[g] <= 8'h00;
        blink_state[g] <= 1'b0;
      end else if (unit_tick) begin
        // Period zero treated as one unit
        if (blink_cnt[g] + 8'h01 >= blink_control_register[g*8 +: 8]) begin
          blink_cnt[g] <= 8'h00;
          blink_state[g] <= ~blink_state[g];
        end else begin
          blink_cnt[g] <= blink_cnt[g] + 8'h01;
        end
      end
    end
  end

  // Attribute word driven in the last cycle before hsync rises
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      frame_addr_data_bus_out <= 16'h0000;
      frame_addr_data_oe_out <= 1'b0;
      high_addr_raster_lines_out <= 4'h0;
      split_code <= 2'b00;
    end else if (hsync_lead_in) begin
      // Attribute field sampled at raster end
      frame_addr_data_bus_out <= {next_zoom, next_dot,
        display_control_register[`RVAO_DC_ATTR_LSB +: 8]};
      frame_addr_data_oe_out <= 1'b1;
      high_addr_raster_lines_out <= {blink_state, next_split};
      split_code <= next_split;
    end else begin
      // Bus released outside the attribute cycle
      frame_addr_data_bus_out <= 16'h0000;
      frame_addr_data_oe_out <= 1'b0;
      high_addr_raster_lines_out <= 4'h0;
    end
  end

  // Word appears exactly one cycle after the lead pulse
  a_word_slot: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    hsync_lead_in |=> frame_addr_data_oe_out)
    else $error("attribute word missing after lead pulse");
  a_word_single: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    frame_addr_data_oe_out |-> $past(hsync_lead_in))
    else $error("attribute word driven without lead pulse");
  a_attr_code: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    hsync_lead_in |=> frame_addr_data_bus_out[7:0] ==
      $past(display_control_register[`RVAO_DC_ATTR_LSB +: 8]))
    else $error("attribute code does not match field");
  a_attr_raster: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !frame_addr_data_oe_out |-> frame_addr_data_bus_out == 16'h0000)
    else $error("attribute bus active between rasters");
  a_dot_outside: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (hsync_lead_in && !area_active_in) |=> frame_addr_data_bus_out[11:8] == 4'h0)
    else $error("scroll dot valid outside area");
  a_dot_window: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (area_start_in && operation_mode_register[`RVAO_OM_SWS]) |=> held_dot == $past(win_dot))
    else $error("window dot not captured");
  a_dot_base: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (area_start_in && !operation_mode_register[`RVAO_OM_SWS]) |=> held_dot == $past(base_dot))
    else $error("base dot not captured");
  a_dot_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !area_start_in |=> $stable(held_dot))
    else $error("scroll dot changed inside area");
  a_zoom_base: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (frame_addr_data_oe_out && high_addr_raster_lines_out[1:0] != 2'b01)
      |-> frame_addr_data_bus_out[15:12] == 4'h0)
    else $error("zoom shown off base screen");
  a_zoom_value: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (hsync_lead_in && next_split == RVAO_SCR_BASE)
      |=> frame_addr_data_bus_out[15:12] == $past(zoom_factor_register))
    else $error("zoom code wrong on base screen");
  a_split_upper: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (hsync_lead_in && screen_sel_in == RVAO_SCR_UPPER &&
      display_control_register[`RVAO_DC_UPPER_EN])
      |=> high_addr_raster_lines_out[1:0] == 2'b10)
    else $error("upper screen code wrong");
  a_split_none: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (hsync_lead_in && display_control_register[`RVAO_DC_LOWER_EN:`RVAO_DC_BASE_EN] == 3'h0)
      |=> high_addr_raster_lines_out[1:0] == 2'b00)
    else $error("split code shown with no screen enabled");
  a_blink_steady: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !unit_tick |=> $stable(blink_state))
    else $error("blink toggled off a unit boundary");
endmodule // rvao_attr_out

// File: rvao_video_latch.sv
`timescale 1ns/1ps
// External latch catching the attribute word for the video shifter
module rvao_video_latch (
  input wire logic clk_sys_in,
  input wire logic oe_in,
  input wire logic [15:0] bus_in,
  input wire logic [3:0] high_in,
  output logic [19:0] word_out
);
  // Capture only in the cycle before hsync rises, hold otherwise
  always_ff @(posedge clk_sys_in) begin
    if (oe_in) begin
      word_out <= {high_in, bus_in};
    end
  end
endmodule // rvao_video_latch

// File: rvao_attr_out_bench.sv
`timescale 1ns/1ps
`include "rvao_map.svh"
module rvao_attr_out_bench;
  import rvao_pkg::*;
  logic clk_sys_in = 1'b0; // System clock
  logic rst_n_in = 1'b0; // Reset, active low
  logic [7:0] addr = 8'h00; // Register address
  logic [15:0] wdata = 16'h0000; // Write data
  logic wr = 1'b0, rd = 1'b0, lead = 1'b0, vs = 1'b0, ast = 1'b0, aact = 1'b0; // Strobes
  rvao_screen_t scr = RVAO_SCR_NONE; // Screen on display
  logic [15:0] rdata, bus; // Read data and frame bus
  logic oe; // Frame bus enable
  logic [3:0] hi; // High address lines
  logic [19:0] word; // Latched attribute word
  int mismatches = 0, total_checks = 0, cycles = 0; // Counters
  rvao_attr_out i_rvao_attr_out (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .hsync_lead_in(lead), .vsync_pulse_in(vs), .area_start_in(ast),
    .area_active_in(aact), .screen_sel_in(scr), .frame_addr_data_bus_out(bus),
    .frame_addr_data_oe_out(oe), .high_addr_raster_lines_out(hi));
  rvao_video_latch i_rvao_video_latch (.clk_sys_in(clk_sys_in), .oe_in(oe), .bus_in(bus),
    .high_in(hi), .word_out(word));
  // Clock at 8 ns period
  always #4 clk_sys_in = ~clk_sys_in;
  // Hang guard
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches = mismatches + 1;
      close_out();
    end
  end
  // Compare seen against expected
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // One-cycle register write
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys_in) {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clk_sys_in) wr <= 1'b0;
  endtask
  // One-cycle read, data checked in the next cycle
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys_in) {rd, addr} <= {1'b1, a};
    @(posedge clk_sys_in) rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Single-cycle pulse: 0 lead, 1 area start, 2 vsync
  task automatic pulse(input int sel);
    @(posedge clk_sys_in);
    case (sel)
      0: lead <= 1'b1;
      1: ast <= 1'b1;
      default: vs <= 1'b1;
    endcase
    @(posedge clk_sys_in) {lead, ast, vs} <= 3'b000;
  endtask
  // End a raster and judge the latched word
  task automatic raster(input logic [19:0] exp);
    pulse(0);
    #1 check({19'h0, oe}, 20'h1);
    @(posedge clk_sys_in) #1;
    check(word, exp);
    check({3'h0, oe, bus}, 20'h0);
    check({hi, bus}, 20'h0);
  endtask
  // Register access, attribute, dot hold, zoom
  task automatic t_fields();
    logic [15:0] d;
    wr_reg(`RVAO_OFS_DISP_CTRL, 16'h0155);
    rd_reg(`RVAO_OFS_DISP_CTRL, d);
    check({4'h0, d}, 20'h00155);
    // Read data stands one cycle only
    @(posedge clk_sys_in) #1 check({4'h0, rdata}, 20'h0);
    rd_reg(8'h1c, d);
    check({4'h0, d}, 20'h0);
    wr_reg(`RVAO_OFS_ZOOM, 16'h000f);
    wr_reg(`RVAO_OFS_BASE_DOT, 16'h0005);
    scr <= RVAO_SCR_BASE;
    aact <= 1'b1;
    pulse(1);
    wr_reg(`RVAO_OFS_BASE_DOT, 16'h0007);
    raster(20'h1f555);
    wr_reg(`RVAO_OFS_DISP_CTRL, 16'h01aa);
    // Latched word keeps the old code until the raster ends
    check(word, 20'h1f555);
    raster(20'h1f5aa);
  endtask
  // All split codes, zoom only on base
  task automatic t_split();
    wr_reg(`RVAO_OFS_DISP_CTRL, 16'h0711);
    for (int s = 0; s < 4; s++) begin
      @(posedge clk_sys_in) scr <= rvao_screen_t'(s);
      raster({2'b00, s[1:0], (s == 1) ? 4'hf : 4'h0, 4'h5, 8'h11});
    end
    wr_reg(`RVAO_OFS_DISP_CTRL, 16'h0011);
    raster(20'h00511);
  endtask
  // Window dot select and inactive area
  task automatic t_window();
    wr_reg(`RVAO_OFS_OP_MODE, 16'h0001);
    wr_reg(`RVAO_OFS_WIN_DOT, 16'h0009);
    pulse(1);
    raster(20'h00911);
    @(posedge clk_sys_in) aact <= 1'b0;
    raster(20'h00011);
  endtask
  // Blink lines after four-field units
  task automatic t_blink();
    logic [15:0] d;
    for (int n = 0; n < 8; n++) begin
      pulse(2);
      if (n == 3) raster(20'h40011);
    end
    raster(20'h80011);
    // Status shows blink levels, last split code and held dot
    rd_reg(`RVAO_OFS_STATUS, d);
    check({4'h0, d}, 20'h00089);
  endtask
  // Verdict and end of run
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    wr_reg(`RVAO_OFS_BLINK, 16'h0201);
    t_fields();
    t_split();
    t_window();
    t_blink();
    close_out();
  end
endmodule // rvao_attr_out_bench
